// ---- logic/abac_top.sv ----
// address block access control: fetch and operand checking units with windows
//
// Summary of operation
// - separate fetch and operand checking units
// - two 32-bit windows per unit
// - windows moved only in supervisor mode
// - base compared with top eight address bits
// - set mask bits exclude base bits
// - window ignored unless enable bit set
// - privilege field qualifies match on function bit
// - match needs privilege and unmasked bits equal
// - echo operand user attributes on page attribute outputs for external transfers not aborted by write protect
// - cache policy field selects access handling
// - write protect aborts writes, raises error
// - window zero wins when both match
// - no match passes address unchanged
// - page granularity fixed at four kilobytes
// - reset clears every window enable bit
`timescale 1ns/100ps
module abac_top (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // control register move port
    input  wire logic        crm_wr_i,
    input  wire logic        crm_rd_i,
    input  wire logic        crm_super_i,
    input  wire logic [1:0]  crm_sel_i,
    input  wire logic [31:0] crm_wdata_i,
    output logic      [31:0] crm_rdata_o,
    output logic             crm_priv_err_o,
    // instruction fetch access
    input  wire logic        if_req_i,
    input  wire logic [31:0] if_addr_i,
    input  wire logic        if_priv_function_bit_i,
    // data operand access
    input  wire logic        op_req_i,
    input  wire logic [31:0] op_addr_i,
    input  wire logic        op_priv_function_bit_i,
    input  wire logic        op_wr_i,
    input  wire logic        op_ext_i,
    // fetch results
    output logic             if_valid_o,
    output logic      [31:0] if_addr_o,
    output logic             if_hit_o,
    output logic      [1:0]  if_cache_policy_o,
    // operand results
    output logic             op_valid_o,
    output logic      [31:0] op_addr_o,
    output logic             op_hit_o,
    output logic      [1:0]  op_cache_policy_o,
    output logic             op_access_error_o,
    // page push and invalidate by page
    input  wire logic [31:0] pg_addr_i,
    output logic      [31:0] pg_base_o,
    // user page attribute pins
    output logic             page_attribute_out_high_o,
    output logic             page_attribute_out_low_o
);

    // ********************
    // state
    // ********************
    typedef struct packed {
        logic [31:0] iwin0;
        logic [31:0] iwin1;
        logic [31:0] dwin0;
        logic [31:0] dwin1;
        logic [31:0] rdata;
        logic        priv_err;
        logic        i_valid;
        logic [31:0] i_addr;
        logic        i_hit;
        logic [1:0]  i_pol;
        logic        d_valid;
        logic [31:0] d_addr;
        logic        d_hit;
        logic [1:0]  d_pol;
        logic        d_err;
        logic [31:0] pg_base;
        logic [1:0]  upa;
    } abac_state_t;

    abac_state_t st_reg;
    abac_state_t st_next;

    // ********************
    // checking units
    // ********************
    abac_chk_if fchk ();
    abac_chk_if ochk ();

    abac_check_unit u_fetch_checking_unit (
        .chk (fchk.unit)
    );
    abac_check_unit u_operand_checking_unit (
        .chk (ochk.unit)
    );

    // fetches never write, so write protect cannot fault them
    assign fchk.win0     = st_reg.iwin0;
    assign fchk.win1     = st_reg.iwin1;
    assign fchk.req      = if_req_i;
    assign fchk.addr_hi  = if_addr_i[31:24];
    assign fchk.priv_bit = if_priv_function_bit_i;
    assign fchk.wr       = 1'b0;
    assign ochk.win0     = st_reg.dwin0;
    assign ochk.win1     = st_reg.dwin1;
    assign ochk.req      = op_req_i;
    assign ochk.addr_hi  = op_addr_i[31:24];
    assign ochk.priv_bit = op_priv_function_bit_i;
    assign ochk.wr       = op_wr_i;

    function automatic logic [31:0] win_write(input logic [31:0] d);
        return d & abac_pkg::WIN_WMASK;
    endfunction

    // ********************
    // next state
    // ********************
    always_comb begin
        st_next          = st_reg;
        st_next.priv_err = 1'b0;
        // user-mode moves are refused and flagged
        if ((crm_wr_i || crm_rd_i) && !crm_super_i) begin
            st_next.priv_err = 1'b1;
        end
        if (crm_wr_i && crm_super_i) begin
            case (crm_sel_i)
                abac_pkg::SEL_IWIN0: st_next.iwin0 = win_write(crm_wdata_i);
                abac_pkg::SEL_IWIN1: st_next.iwin1 = win_write(crm_wdata_i);
                abac_pkg::SEL_DWIN0: st_next.dwin0 = win_write(crm_wdata_i);
                abac_pkg::SEL_DWIN1: st_next.dwin1 = win_write(crm_wdata_i);
                default: st_next.iwin0 = st_reg.iwin0;
            endcase
        end
        if (crm_rd_i && crm_super_i) begin
            case (crm_sel_i)
                abac_pkg::SEL_IWIN0: st_next.rdata = st_reg.iwin0;
                abac_pkg::SEL_IWIN1: st_next.rdata = st_reg.iwin1;
                abac_pkg::SEL_DWIN0: st_next.rdata = st_reg.dwin0;
                abac_pkg::SEL_DWIN1: st_next.rdata = st_reg.dwin1;
                default: st_next.rdata = 32'h0000_0000;
            endcase
        end
        // addresses pass untranslated, one cycle later
        st_next.i_valid = if_req_i;
        st_next.i_addr  = if_addr_i;
        st_next.i_hit   = fchk.hit;
        st_next.i_pol   = fchk.policy;
        st_next.d_valid = op_req_i;
        st_next.d_addr  = op_addr_i;
        st_next.d_hit   = ochk.hit;
        st_next.d_pol   = ochk.policy;
        st_next.d_err   = ochk.fault;
        // attribute pins follow the latest external operand transfer that write protect does not abort
        if (op_req_i && op_ext_i && !ochk.fault) begin
            st_next.upa = ochk.uattr;
        end else if (op_req_i && op_ext_i) begin
            st_next.upa = st_reg.upa;
        end
        st_next.pg_base = {pg_addr_i[31:abac_pkg::PAGE_SHIFT],
                           {abac_pkg::PAGE_SHIFT{1'b0}}};
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_reg         <= '0;
            // window enables cleared, access control off
            st_reg.iwin0   <= abac_pkg::WIN_RESET;
            st_reg.iwin1   <= abac_pkg::WIN_RESET;
            st_reg.dwin0   <= abac_pkg::WIN_RESET;
            st_reg.dwin1   <= abac_pkg::WIN_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ********************
    // outputs
    // ********************
    assign crm_rdata_o               = st_reg.rdata;
    assign crm_priv_err_o            = st_reg.priv_err;
    assign if_valid_o                = st_reg.i_valid;
    assign if_addr_o                 = st_reg.i_addr;
    assign if_hit_o                  = st_reg.i_hit;
    assign if_cache_policy_o         = st_reg.i_pol;
    assign op_valid_o                = st_reg.d_valid;
    assign op_addr_o                 = st_reg.d_addr;
    assign op_hit_o                  = st_reg.d_hit;
    assign op_cache_policy_o         = st_reg.d_pol;
    assign op_access_error_o         = st_reg.d_err;
    assign pg_base_o                 = st_reg.pg_base;
    assign page_attribute_out_high_o = st_reg.upa[1];
    assign page_attribute_out_low_o  = st_reg.upa[0];

    // ********************
    // assertions
    // ********************
    user_move_blocked_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        crm_wr_i && !crm_super_i |=> $stable(st_reg.iwin0) && $stable(st_reg.dwin1))
        else $error("user mode changed a window");

    reset_clears_en_a: assert property (@(posedge ref_clk_i)
        rst_i |=> !st_reg.iwin0[15] && !st_reg.iwin1[15] && !st_reg.dwin0[15] && !st_reg.dwin1[15])
        else $error("window enable survived reset");

    reserved_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_reg.dwin0 & ~abac_pkg::WIN_WMASK) == 32'h0000_0000)
        else $error("reserved window bits set");

    addr_passthru_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        op_req_i |=> op_valid_o && op_addr_o == $past(op_addr_i))
        else $error("operand address altered");

    disabled_nohit_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        op_req_i && !st_reg.dwin0[15] && !st_reg.dwin1[15] |=> !op_hit_o)
        else $error("hit with both windows disabled");

    wp_error_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        op_access_error_o |-> $past(op_wr_i) && $past(ochk.hit))
        else $error("access error without protected write");

    read_no_error_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        op_req_i && !op_wr_i |=> !op_access_error_o)
        else $error("read raised access error");

    win0_priority_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        op_req_i && st_reg.dwin0[15] && st_reg.dwin0[14:13] == 2'h2
        && st_reg.dwin0[23:16] == 8'hFF
        |=> op_cache_policy_o == $past(st_reg.dwin0[6:5]))
        else $error("window zero lost priority");

    page_fixed_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        1'b1 |=> pg_base_o[11:0] == 12'h000 && pg_base_o[31:12] == $past(pg_addr_i[31:12]))
        else $error("page base not four kilobyte aligned");

    // ********************
    // field views used by the checks
    // ********************
    logic       crm_user;
    logic       d0_en;
    logic       d1_en;
    logic       d0_any;
    logic [1:0] d0_priv;
    logic [7:0] d0_mask;
    logic [7:0] d0_diff;
    logic [7:0] d1_diff;
    logic       i_none;

    assign crm_user = (crm_wr_i || crm_rd_i) && !crm_super_i;
    assign d0_en    = st_reg.dwin0[abac_pkg::EN_BIT];
    assign d1_en    = st_reg.dwin1[abac_pkg::EN_BIT];
    assign d0_any   = st_reg.dwin0[abac_pkg::PRIV_HI];
    assign d0_priv  = st_reg.dwin0[abac_pkg::PRIV_HI:abac_pkg::PRIV_LO];
    assign d0_mask  = st_reg.dwin0[abac_pkg::MASK_HI:abac_pkg::MASK_LO];
    assign d0_diff  = (st_reg.dwin0[abac_pkg::BASE_HI:abac_pkg::BASE_LO] ^ op_addr_i[31:24])
                      & ~d0_mask;
    assign d1_diff  = (st_reg.dwin1[abac_pkg::BASE_HI:abac_pkg::BASE_LO] ^ op_addr_i[31:24])
                      & ~st_reg.dwin1[abac_pkg::MASK_HI:abac_pkg::MASK_LO];
    assign i_none   = !st_reg.iwin0[abac_pkg::EN_BIT] && !st_reg.iwin1[abac_pkg::EN_BIT];

    fetch_no_fault_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !fchk.fault)
        else $error("fetch raised access error");

    user_move_rest_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        crm_wr_i && !crm_super_i |=> $stable(st_reg.iwin1) && $stable(st_reg.dwin0))
        else $error("user mode changed another window");

    user_read_blocked_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        crm_rd_i && !crm_super_i |=> $stable(crm_rdata_o))
        else $error("user mode read a window");

    priv_err_set_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        crm_user |=> crm_priv_err_o)
        else $error("user move not flagged");

    priv_err_quiet_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !crm_user |=> !crm_priv_err_o)
        else $error("privilege error without user move");

    super_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        crm_wr_i && crm_super_i && crm_sel_i == abac_pkg::SEL_DWIN1
        |=> st_reg.dwin1 == ($past(crm_wdata_i) & abac_pkg::WIN_WMASK))
        else $error("supervisor write did not land");

    super_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        crm_rd_i && crm_super_i && crm_sel_i == abac_pkg::SEL_IWIN1
        |=> crm_rdata_o == $past(st_reg.iwin1))
        else $error("supervisor read returned a wrong word");

    reserved_rest_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ((st_reg.iwin0 | st_reg.iwin1 | st_reg.dwin1) & ~abac_pkg::WIN_WMASK) == 32'h0000_0000)
        else $error("reserved bits set in another window");

    fetch_passthru_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        if_req_i |=> if_valid_o && if_addr_o == $past(if_addr_i))
        else $error("fetch address altered");

    op_idle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !op_req_i |=> !op_valid_o && !op_hit_o && !op_access_error_o)
        else $error("operand result without request");

    fetch_idle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !if_req_i |=> !if_valid_o && !if_hit_o)
        else $error("fetch result without request");

    op_miss_policy_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !op_hit_o |-> op_cache_policy_o == abac_pkg::CP_DEFAULT)
        else $error("operand miss with non-default policy");

    fetch_disabled_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        if_req_i && i_none |=> !if_hit_o)
        else $error("fetch hit with both windows disabled");

    user_window_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        op_req_i && op_priv_function_bit_i && !d1_en && d0_priv == abac_pkg::PRIV_USER
        |=> !op_hit_o)
        else $error("user window matched supervisor access");

    super_window_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        op_req_i && !op_priv_function_bit_i && !d1_en && d0_priv == abac_pkg::PRIV_SUPER
        |=> !op_hit_o)
        else $error("supervisor window matched user access");

    full_match_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        op_req_i && d0_en && d0_any && d0_diff == 8'h00 |=> op_hit_o)
        else $error("matching access missed");

    mask_all_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        op_req_i && d0_en && d0_any && d0_mask == 8'hFF |=> op_hit_o)
        else $error("fully masked window missed");

    base_miss_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        op_req_i && d0_diff != 8'h00 && d1_diff != 8'h00 |=> !op_hit_o)
        else $error("base mismatch still hit");

    wp_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        op_req_i && op_wr_i && d0_en && d0_any && st_reg.dwin0[abac_pkg::WP_BIT]
        && d0_mask == 8'hFF |=> op_access_error_o)
        else $error("protected write not aborted");

    upa_fault_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        op_req_i && op_ext_i && ochk.fault |=> $stable(st_reg.upa))
        else $error("aborted transfer changed attribute pins");

    upa_echo_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        op_req_i && op_ext_i && !ochk.fault
        |=> {page_attribute_out_high_o, page_attribute_out_low_o} == $past(ochk.uattr))
        else $error("attribute pins do not echo the window");

    miss_quiet_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (ochk.hit || ochk.uattr == 2'h0) && (fchk.hit || fchk.uattr == 2'h0))
        else $error("miss carried user attributes");

    reset_outputs_a: assert property (@(posedge ref_clk_i)
        rst_i |=> !op_valid_o && !if_valid_o && !crm_priv_err_o && !op_access_error_o)
        else $error("outputs active after reset");

endmodule

// ---- logic/abac_pkg.sv ----
// package of constants and types for the address block access control block
package abac_pkg;

    // ********************
    // window register field positions
    // ********************
    localparam int BASE_HI  = 31;
    localparam int BASE_LO  = 24;
    localparam int MASK_HI  = 23;
    localparam int MASK_LO  = 16;
    localparam int EN_BIT   = 15;
    localparam int PRIV_HI  = 14;
    localparam int PRIV_LO  = 13;
    localparam int UA_HI    = 9;
    localparam int UA_LO    = 8;
    localparam int CP_HI    = 6;
    localparam int CP_LO    = 5;
    localparam int WP_BIT   = 2;

    // writable bits; all others read as zero
    localparam logic [31:0] WIN_WMASK  = 32'hFFFF_E364;
    localparam logic [31:0] WIN_RESET  = 32'h0000_0000;
    localparam logic [31:0] EN_CLR     = 32'hFFFF_7FFF;

    // ********************
    // register selects for the control register move port
    // ********************
    localparam logic [1:0] SEL_IWIN0 = 2'h0;
    localparam logic [1:0] SEL_IWIN1 = 2'h1;
    localparam logic [1:0] SEL_DWIN0 = 2'h2;
    localparam logic [1:0] SEL_DWIN1 = 2'h3;

    // ********************
    // privilege field and cache policy codes
    // ********************
    localparam logic [1:0] PRIV_USER  = 2'h0;
    localparam logic [1:0] PRIV_SUPER = 2'h1;
    localparam logic [1:0] CP_WTHRU   = 2'h0;
    localparam logic [1:0] CP_COPYB   = 2'h1;
    localparam logic [1:0] CP_NC_SER  = 2'h2;
    localparam logic [1:0] CP_NC      = 2'h3;

    // default policy when no window matches
    localparam logic [1:0] CP_DEFAULT = 2'h0;

    // fixed page size for push/invalidate by page, in bytes
    localparam int          PAGE_BYTES = 4096;
    localparam int          PAGE_SHIFT = $clog2(PAGE_BYTES);

endpackage

// ---- logic/abac_chk_if.sv ----
// interface carrying one access and its verdict between top and checking unit
`timescale 1ns/100ps
interface abac_chk_if;
    logic [31:0] win0;
    logic [31:0] win1;
    logic        req;
    logic [7:0]  addr_hi;
    logic        priv_bit;
    logic        wr;
    logic        hit;
    logic [1:0]  policy;
    logic [1:0]  uattr;
    logic        fault;

    modport owner (
        output win0, win1, req, addr_hi, priv_bit, wr,
        input  hit, policy, uattr, fault
    );
    modport unit (
        input  win0, win1, req, addr_hi, priv_bit, wr,
        output hit, policy, uattr, fault
    );
endinterface

// ---- logic/abac_check_unit.sv ----
// one access checking unit: two windows, priority to window zero
`timescale 1ns/100ps
module abac_check_unit (
    abac_chk_if.unit chk
);

    function automatic logic win_match(
        input logic [31:0] w,
        input logic [7:0]  a,
        input logic        p
    );
        logic priv_ok;
        logic addr_ok;
        priv_ok = 1'b1;
        if (w[abac_pkg::PRIV_HI:abac_pkg::PRIV_LO] == abac_pkg::PRIV_USER)
            priv_ok = !p;
        else if (w[abac_pkg::PRIV_HI:abac_pkg::PRIV_LO] == abac_pkg::PRIV_SUPER)
            priv_ok = p;
        addr_ok = ((w[abac_pkg::BASE_HI:abac_pkg::BASE_LO] ^ a)
                   & ~w[abac_pkg::MASK_HI:abac_pkg::MASK_LO]) == 8'h00;
        return w[abac_pkg::EN_BIT] && priv_ok && addr_ok;
    endfunction

    logic        m0;
    logic        m1;
    logic [31:0] sel;

    always_comb begin
        m0  = win_match(chk.win0, chk.addr_hi, chk.priv_bit);
        m1  = win_match(chk.win1, chk.addr_hi, chk.priv_bit);
        sel = m0 ? chk.win0 : chk.win1;
        chk.hit    = chk.req && (m0 || m1);
        // no match passes through with default policy
        chk.policy = chk.hit ? sel[abac_pkg::CP_HI:abac_pkg::CP_LO] : abac_pkg::CP_DEFAULT;
        chk.uattr  = chk.hit ? sel[abac_pkg::UA_HI:abac_pkg::UA_LO] : 2'h0;
        chk.fault  = chk.hit && chk.wr && sel[abac_pkg::WP_BIT];
    end

endmodule

// ---- sim/abac_cpu_model.sv ----
// processor side model: issues fetch and operand accesses
`timescale 1ns/100ps
module abac_cpu_model (
    // clock
    input  wire logic        clk_i,
    // fetch access
    output logic             if_req_o,
    output logic      [31:0] if_addr_o,
    output logic             if_fc_o,
    // operand access
    output logic             op_req_o,
    output logic      [31:0] op_addr_o,
    output logic             op_fc_o,
    output logic             op_wr_o,
    output logic             op_ext_o
);
    // ****************
    // access drivers
    // ****************
    initial begin
        {if_req_o, if_fc_o, op_req_o, op_fc_o, op_wr_o, op_ext_o} = 6'h00;
        if_addr_o = 32'h0000_0000;
        op_addr_o = 32'h0000_0000;
    end

    // released lines show the inverse so a stale address never looks valid
    task automatic fetch(input logic [31:0] a, input logic s);
        @(negedge clk_i);
        {if_req_o, if_addr_o, if_fc_o} = {1'b1, a, s};
        @(negedge clk_i);
        {if_req_o, if_addr_o, if_fc_o} = {1'b0, ~a, ~s};
    endtask

    task automatic oper(input logic [31:0] a, input logic s, w, e);
        @(negedge clk_i);
        {op_req_o, op_addr_o, op_fc_o, op_wr_o, op_ext_o} = {1'b1, a, s, w, e};
        @(negedge clk_i);
        {op_req_o, op_addr_o, op_fc_o, op_wr_o, op_ext_o} = {1'b0, ~a, ~s, ~w, ~e};
    endtask
endmodule

// ---- sim/abac_tb.sv ----
// self-checking testbench for the address block access control block
`timescale 1ns/100ps
module testbench;
    logic        ref_clk   = 1'b0;
    logic        rst       = 1'b1;
    logic        crm_wr    = 1'b0;
    logic        crm_rd    = 1'b0;
    logic        crm_super = 1'b1;
    logic [1:0]  crm_sel   = 2'h0;
    logic [31:0] crm_wdata = 32'h0000_0000;
    logic [31:0] pg_addr   = 32'h0000_0000;
    logic [31:0] rdata, if_ao, op_ao, pg_base, if_a, op_a;
    logic        perr, if_v, if_h, op_v, op_h, op_err, pa_hi, pa_lo;
    logic        if_rq, if_fc, op_rq, op_fc, op_wr, op_ext;
    logic [1:0]  if_cp, op_cp;
    int          n_errors, checks_done, cycles;

    always #12.5 ref_clk = ~ref_clk;

    abac_cpu_model cpu (.clk_i(ref_clk), .if_req_o(if_rq), .if_addr_o(if_a),
        .if_fc_o(if_fc), .op_req_o(op_rq), .op_addr_o(op_a), .op_fc_o(op_fc),
        .op_wr_o(op_wr), .op_ext_o(op_ext));

    abac_top DUT (.ref_clk_i(ref_clk), .rst_i(rst), .crm_wr_i(crm_wr),
        .crm_rd_i(crm_rd), .crm_super_i(crm_super), .crm_sel_i(crm_sel),
        .crm_wdata_i(crm_wdata), .crm_rdata_o(rdata), .crm_priv_err_o(perr),
        .if_req_i(if_rq), .if_addr_i(if_a), .if_priv_function_bit_i(if_fc),
        .op_req_i(op_rq), .op_addr_i(op_a), .op_priv_function_bit_i(op_fc),
        .op_wr_i(op_wr), .op_ext_i(op_ext), .if_valid_o(if_v), .if_addr_o(if_ao),
        .if_hit_o(if_h), .if_cache_policy_o(if_cp), .op_valid_o(op_v),
        .op_addr_o(op_ao), .op_hit_o(op_h), .op_cache_policy_o(op_cp),
        .op_access_error_o(op_err), .pg_addr_i(pg_addr), .pg_base_o(pg_base),
        .page_attribute_out_high_o(pa_hi), .page_attribute_out_low_o(pa_lo));

    // ****************
    // shared tasks
    // ****************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [31:0] win(logic [7:0] b, m, logic [1:0] s, u, c, logic w);
        return {b, m, 1'b1, s, 3'h0, u, 1'b0, c, 2'h0, w, 2'h0};
    endfunction

    task automatic crm(input logic w, input logic [1:0] s, input logic [31:0] d,
                       input logic su);
        @(negedge ref_clk);
        {crm_wr, crm_rd, crm_sel, crm_wdata, crm_super} = {w, ~w, s, d, su};
        @(negedge ref_clk);
        {crm_wr, crm_rd, crm_super} = 3'h1;
    endtask

    task automatic op_chk(input logic [31:0] a, input logic s, w, e, h,
                          input logic [1:0] c, input logic er);
        cpu.oper(a, s, w, e);
        chk("op_valid", 1, op_v);
        chk("op_addr", a, op_ao);
        chk("op_hit", h, op_h);
        chk("op_policy", c, op_cp);
        chk("op_error", er, op_err);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            $display("Error timeout");
            tally_and_finish();
        end
    end

    // ****************
    // scenarios
    // ****************
    task automatic t_reset;
        for (int s = 0; s < 4; s++) begin
            crm(0, 2'(s), 0, 1);
            chk("win_enable", 0, rdata & 32'h0000_8000);
        end
        op_chk(32'h1200_0000, 0, 0, 1, 0, abac_pkg::CP_DEFAULT, 0);
        cpu.fetch(32'h4000_0100, 1);
        chk("if_hit_rst", 0, if_h);
        $display("test reset done");
    endtask

    task automatic t_regs;
        for (int s = 0; s < 4; s++) begin
            crm(1, 2'(s), 32'hFFFF_FFFF, 1);
            crm(0, 2'(s), 0, 1);
            chk("win_rw", 32'hFFFF_E364, rdata);
        end
        crm(1, abac_pkg::SEL_DWIN1, 0, 0);
        chk("priv_err", 1, perr);
        crm(0, abac_pkg::SEL_DWIN1, 0, 1);
        chk("user_move", 32'hFFFF_E364, rdata);
        for (int s = 0; s < 4; s++) crm(1, 2'(s), 0, 1);
        crm(0, abac_pkg::SEL_DWIN1, 0, 0);
        chk("user_read_err", 1, perr);
        chk("user_read", 32'hFFFF_E364, rdata);
        $display("test registers done");
    endtask

    task automatic t_policy;
        for (int c = 0; c < 4; c++) begin
            crm(1, abac_pkg::SEL_DWIN0, win(8'h12, 8'h00, 2'h2, 2'(c), 2'(c), 0), 1);
            op_chk(32'h1234_5678, 0, 0, 1, 1, 2'(c), 0);
            chk("attr", c, {pa_hi, pa_lo});
        end
        op_chk(32'h1334_5678, 0, 0, 1, 0, abac_pkg::CP_DEFAULT, 0);
        crm(1, abac_pkg::SEL_DWIN0, win(8'h12, 8'h01, 2'h2, 0, 2'h1, 0), 1);
        op_chk(32'h1300_0000, 1, 0, 0, 1, 2'h1, 0);
        op_chk(32'h1000_0000, 1, 0, 0, 0, abac_pkg::CP_DEFAULT, 0);
        crm(1, abac_pkg::SEL_DWIN0, win(8'h12, 0, 2'h2, 0, 2'h1, 0) & 32'hFFFF_7FFF, 1);
        op_chk(32'h1200_0000, 1, 0, 0, 0, abac_pkg::CP_DEFAULT, 0);
        $display("test policy done");
    endtask

    task automatic t_priv;
        logic h;
        for (int s = 0; s < 4; s++) begin
            for (int f = 0; f < 2; f++) begin
                h = (s > 1) || (s == f);
                crm(1, abac_pkg::SEL_DWIN0, win(8'hA0, 0, 2'(s), 0, 2'h3, 0), 1);
                op_chk(32'hA000_0000, 1'(f), 0, 0, h, h ? 2'h3 : 2'h0, 0);
            end
        end
        $display("test privilege done");
    endtask

    task automatic t_wp_prio;
        crm(1, abac_pkg::SEL_DWIN0, win(8'h55, 8'hFF, 2'h2, 2'h1, 2'h3, 1), 1);
        crm(1, abac_pkg::SEL_DWIN1, win(8'h55, 0, 2'h2, 2'h2, 2'h1, 0), 1);
        op_chk(32'h5500_0010, 1, 1, 1, 1, 2'h3, 1);
        chk("attr_fault", 2'h0, {pa_hi, pa_lo});
        op_chk(32'h5500_0010, 1, 0, 1, 1, 2'h3, 0);
        chk("attr_prio", 2'h1, {pa_hi, pa_lo});
        crm(1, abac_pkg::SEL_DWIN0, 0, 1);
        op_chk(32'h5500_0010, 1, 1, 1, 1, 2'h1, 0);
        chk("attr_win1", 2'h2, {pa_hi, pa_lo});
        crm(1, abac_pkg::SEL_DWIN1, 0, 1);
        $display("test protect and priority done");
    endtask

    task automatic t_fetch;
        crm(1, abac_pkg::SEL_IWIN0, win(8'h40, 0, 2'h1, 0, 2'h2, 1), 1);
        crm(1, abac_pkg::SEL_IWIN1, win(8'h41, 0, 2'h1, 0, 2'h1, 0), 1);
        for (int i = 0; i < 2; i++) begin
            cpu.fetch({8'h40 + 8'(i), 24'h00_0100}, 1);
            chk("if_valid", 1, if_v);
            chk("if_addr", {8'h40 + 8'(i), 24'h00_0100}, if_ao);
            chk("if_hit", 1, if_h);
            chk("if_policy", 2'h2 - 2'(i), if_cp);
        end
        op_chk(32'h4000_0100, 1, 0, 0, 0, abac_pkg::CP_DEFAULT, 0);
        $display("test fetch unit done");
    endtask

    task automatic t_page;
        @(negedge ref_clk);
        pg_addr = 32'h1234_5FFF;
        @(negedge ref_clk);
        chk("pg_base", 32'h1234_5000, pg_base);
        pg_addr = 32'hFFFF_FFFF;
        @(negedge ref_clk);
        chk("pg_base", 32'hFFFF_F000, pg_base);
        $display("test page done");
    endtask

    task automatic t_rerst;
        crm(1, abac_pkg::SEL_DWIN0, win(8'h12, 0, 2'h2, 0, 2'h1, 0), 1);
        @(negedge ref_clk);
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        t_reset();
        $display("test mid-run reset done");
    endtask

    initial begin
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        t_reset();
        t_regs();
        t_policy();
        t_priv();
        t_wp_prio();
        t_fetch();
        t_page();
        t_rerst();
        tally_and_finish();
    end
endmodule
